// ==== common/serial_link_if.sv ====
// serial line between the documented device end and its remote partner
// assumes: both ends run on the same clk; the line pulls high when undriven
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic dev_txd_o;   // device serial out
	logic dev_txd_oe;  // device owns its transmit pin
	logic far_txd_o;   // partner serial out
	logic far_txd_oe;
	logic dev_rxd;     // line seen by device receiver
	logic far_rxd;     // line seen by partner receiver

	// ----------------------------------------------------------------
	// resolve undriven pins to idle high
	// ----------------------------------------------------------------
	assign far_rxd = dev_txd_oe ? dev_txd_o : 1'b1;
	assign dev_rxd = far_txd_oe ? far_txd_o : 1'b1;

	modport device (output dev_txd_o, output dev_txd_oe, input dev_rxd);
	modport far    (output far_txd_o, output far_txd_oe, input far_rxd);
endinterface : serial_link_if
`default_nettype wire

// ==== common/sfr_pkg.sv ====
// package of constants shared by both ends of the async serial link
// assumes: single 10 MHz clock, used through package::name only
package sfr_pkg;
	// ----------------------------------------------------------------
	// divider and frame
	// ----------------------------------------------------------------
	localparam int          DIV_W        = 13;
	localparam logic [12:0] DIV_RESET    = 13'h0001;
	localparam logic [3:0]  FRAME_8      = 4'hA;  // start + 8 + stop
	localparam logic [3:0]  FRAME_9      = 4'hB;  // start + 9 + stop
	localparam logic [3:0]  BRK_10       = 4'hA;
	localparam logic [3:0]  BRK_11       = 4'hB;
	localparam logic [3:0]  BRK_13       = 4'hD;
	localparam logic [3:0]  BRK_14       = 4'hE;
	localparam logic [3:0]  OS_RATE      = 4'hF;  // sixteen ticks a bit, minus one
	localparam logic [3:0]  OS_MID       = 4'h7;  // mid-bit sample point
	localparam logic [8:0]  DATA_RESET   = 9'h000;

	// ----------------------------------------------------------------
	// transmit shifter contents
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SH_DATA  = 2'b00,
		SH_BREAK = 2'b01,
		SH_IDLE  = 2'b10
	} shift_kind_t;

	typedef enum logic [1:0] {
		RX_WAIT  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} rx_state_t;

	// break length from long_break_sel and nine_bit_sel
	function automatic logic [3:0] break_len(input logic lng,
	                                         input logic nine);
		case ({lng, nine})
			2'b00:   break_len = BRK_10;
			2'b01:   break_len = BRK_11;
			2'b10:   break_len = BRK_13;
			default: break_len = BRK_14;
		endcase
	endfunction : break_len

	// frame length in bit times
	function automatic logic [3:0] frame_len(input logic nine);
		frame_len = nine ? FRAME_9 : FRAME_8;
	endfunction : frame_len
endpackage : sfr_pkg

// ==== dv/sci_link_asserts.sv ====
// assertions on the device end of the serial link
// assumes: baud_div of 1, so one bit time is sixteen clocks
`timescale 1ns/1ps
`default_nettype none
module sci_link_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic dev_txd_o,
	input wire logic dev_txd_oe,
	input wire logic transmitter_on,
	input wire logic receiver_on,
	input wire logic long_break_sel,
	input wire logic nine_bit_sel,
	input wire logic tx_write,
	input wire logic tx_buffer_empty_flag,
	input wire logic tx_complete_flag,
	input wire logic rx_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// length of the current low stretch on the pin
	// ----------------------------------------------------------------
	logic [10:0] low_run;
	logic [10:0] brk_max;
	logic [10:0] data_max;

	// one break spans the selected length; a held control chains
	// breaks back to back, so a long stretch is a multiple of it
	assign brk_max = long_break_sel ? (nine_bit_sel ? 11'h0E0 : 11'h0D0)
	                                : (nine_bit_sel ? 11'h0B0 : 11'h0A0);
	// a data frame is low at most for its start bit and zero data
	assign data_max = nine_bit_sel ? 11'h0A0 : 11'h090;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			low_run <= 11'h000;
		else if (dev_txd_oe && !dev_txd_o)
			low_run <= low_run + 11'h001;
		else
			low_run <= 9'h000;
	end

	// ----------------------------------------------------------------
	// pin and flag relations
	// ----------------------------------------------------------------
	idle_high_a: assert property (
		tx_complete_flag && dev_txd_oe |-> dev_txd_o)
		else $error("pin low while idle");
	done_empty_a: assert property (
		$rose(tx_complete_flag) |-> tx_buffer_empty_flag)
		else $error("complete with data waiting");
	hold_pin_a: assert property (
		!tx_complete_flag && dev_txd_oe |=> dev_txd_oe)
		else $error("pin released while busy");
	take_pin_a: assert property (
		$rose(transmitter_on) |=> dev_txd_oe)
		else $error("pin not taken");
	// a stretch ends as data or as a whole number of breaks
	break_len_a: assert property (
		$rose(dev_txd_o) && dev_txd_oe |->
		low_run <= data_max || low_run % brk_max == 11'h000)
		else $error("low stretch not whole breaks");
	bit_time_a: assert property (
		$rose(dev_txd_o) && dev_txd_oe |-> low_run[3:0] == 4'h0)
		else $error("low stretch not whole bits");
	empty_load_a: assert property (
		$rose(tx_buffer_empty_flag) |-> !tx_complete_flag)
		else $error("empty without shifter load");
	empty_fall_a: assert property (
		$fell(tx_buffer_empty_flag) |-> $past(tx_write))
		else $error("empty fell without write");
	rx_off_a: assert property (
		!receiver_on [*2] |-> !rx_valid)
		else $error("reception while receiver off");
	start_bit_a: assert property (
		$fell(dev_txd_o) && dev_txd_oe |-> !dev_txd_o [*8])
		else $error("start bit too short");
endmodule : sci_link_asserts
`default_nettype wire

// ==== dv/uart_break_idle_framing_tb.sv ====
// self-checking bench: device end and partner end joined by the link
// assumes: baud_div of 1, so a bit is sixteen clocks of 100 ns
`timescale 1ns/1ps
`default_nettype none
module uart_break_idle_framing_tb;
	logic       clk            = 1'b0;
	logic       nrst           = 1'b0;
	logic       transmitter_on = 1'b0;
	logic       receiver_on    = 1'b0;
	logic       send_break_ctl = 1'b0;
	logic       long_break_sel = 1'b0;
	logic       nine_bit_sel   = 1'b0;
	logic       tx_write       = 1'b0;
	logic [8:0] tx_wdata       = 9'h000;
	logic       send_valid     = 1'b0;
	logic [8:0] send_data      = 9'h000;
	logic       tx_buffer_empty_flag;
	logic       tx_complete_flag;
	logic       send_ready;
	logic       d_rx_valid;
	logic [8:0] d_rx_data;
	logic       d_fe;
	logic       f_rx_valid;
	logic [8:0] f_rx_data;
	logic       f_fe;
	int         errors  = 0;
	int         n_tests = 0;
	int         run     = 0;
	int         max_run = 0;
	int         n_fe    = 0;
	int         n_drx   = 0;
	int         i;
	int         k;
	int         blen[4] = '{10, 11, 13, 14};

	// ----------------------------------------------------------------
	// the two ends and the checker
	// ----------------------------------------------------------------
	serial_link_if link ();
	sci_dev_end i_sci_dev_end (.clk(clk), .nrst(nrst), .ce(1'b1),
		.link(link), .baud_div(13'h0001), .transmitter_on(transmitter_on),
		.receiver_on(receiver_on), .send_break_ctl(send_break_ctl),
		.long_break_sel(long_break_sel), .nine_bit_sel(nine_bit_sel),
		.tx_write(tx_write), .tx_wdata(tx_wdata),
		.tx_buffer_empty_flag(tx_buffer_empty_flag),
		.tx_complete_flag(tx_complete_flag), .rx_valid(d_rx_valid),
		.rx_data(d_rx_data), .framing_error_flag(d_fe));
	sci_far_end i_sci_far_end (.clk(clk), .nrst(nrst), .ce(1'b1),
		.link(link), .baud_div(13'h0001), .nine_bit_sel(nine_bit_sel),
		.send_valid(send_valid), .send_data(send_data),
		.send_ready(send_ready), .rx_valid(f_rx_valid),
		.rx_data(f_rx_data), .framing_error_flag(f_fe));
	sci_link_asserts i_sci_link_asserts (.clk(clk), .nrst(nrst),
		.dev_txd_o(link.dev_txd_o), .dev_txd_oe(link.dev_txd_oe),
		.transmitter_on(transmitter_on), .receiver_on(receiver_on),
		.long_break_sel(long_break_sel), .nine_bit_sel(nine_bit_sel),
		.tx_write(tx_write), .tx_buffer_empty_flag(tx_buffer_empty_flag),
		.tx_complete_flag(tx_complete_flag), .rx_valid(d_rx_valid));

	always #50 clk = ~clk;

	// low stretch at the partner, errored frames, device receptions
	always @(negedge clk) begin
		run = (link.far_rxd === 1'b0) ? run + 1 : 0;
		if (run > max_run)
			max_run = run;
		if (f_rx_valid === 1'b1 && f_fe === 1'b1)
			n_fe++;
		if (d_rx_valid === 1'b1)
			n_drx++;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic dev_send(input logic [8:0] d);
		@(posedge clk);
		tx_write <= 1'b1;
		tx_wdata <= d;
		@(posedge clk);
		tx_write <= 1'b0;
	endtask : dev_send

	// request stands until the partner takes it on a bit tick
	task automatic far_send(input logic [8:0] d);
		int j;
		@(posedge clk);
		send_valid <= 1'b1;
		send_data <= d;
		@(posedge clk);
		for (j = 0; j < 400 && send_ready !== 1'b1; j++)
			@(posedge clk);
		send_valid <= 1'b0;
		check(j < 400, "far send not taken");
	endtask : far_send

	// bounded wait for one reception at either end, then compare
	task automatic get_rx(input logic far, input logic [8:0] d,
	                      input logic fe, input string msg);
		int j;
		for (j = 0; j < 600 && (far ? f_rx_valid : d_rx_valid) !== 1'b1; j++)
			@(negedge clk);
		if (far)
			check(f_rx_valid === 1'b1 && f_rx_data === d && f_fe === fe, msg);
		else
			check(d_rx_valid === 1'b1 && d_rx_data === d && d_fe === fe, msg);
		@(negedge clk);
	endtask : get_rx

	// cmp selects the complete flag, otherwise the buffer empty flag
	task automatic wait_flag(input logic cmp, input logic v);
		int j;
		@(negedge clk);
		for (j = 0; j < 3000 &&
		     (cmp ? tx_complete_flag : tx_buffer_empty_flag) !== v; j++)
			@(negedge clk);
		check((cmp ? tx_complete_flag : tx_buffer_empty_flag) === v, "flag");
	endtask : wait_flag

	task automatic complete_run();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// watchdog at about four times the expected run
	initial begin
		#2_000_000;
		errors++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		check({tx_buffer_empty_flag, tx_complete_flag} === 2'b11, "reset");
		nrst <= 1'b1;
		@(posedge clk);
		transmitter_on <= 1'b1;
		receiver_on <= 1'b1;
		idle(4);
		// both directions; bit 8 only travels in nine-bit framing
		for (k = 0; k < 2; k++) begin
			nine_bit_sel <= k[0];
			dev_send(9'h1A5);
			get_rx(1'b1, k ? 9'h1A5 : 9'h0A5, 1'b0, "far rx");
			far_send(9'h15A);
			get_rx(1'b0, k ? 9'h15A : 9'h05A, 1'b0, "dev rx");
			idle(200);
		end
		receiver_on <= 1'b0;
		i = n_drx;
		far_send(9'h033);
		idle(300);
		check(n_drx == i, "rx while off");
		receiver_on <= 1'b1;
		// break after the last data of a message, every length
		for (k = 0; k < 4; k++) begin
			long_break_sel <= k[1];
			nine_bit_sel <= k[0];
			dev_send(9'h1FF);
			wait_flag(1'b0, 1'b1);
			max_run = 0;
			@(posedge clk);
			send_break_ctl <= 1'b1;
			@(posedge clk);
			send_break_ctl <= 1'b0;
			get_rx(1'b1, k[0] ? 9'h1FF : 9'h0FF, 1'b0, "data first");
			get_rx(1'b1, 9'h000, 1'b1, "break");
			wait_flag(1'b1, 1'b1);
			idle(250);
			check(max_run == blen[k] * 16, "break length");
		end
		// control held past two loads keeps queueing breaks
		long_break_sel <= 1'b0;
		nine_bit_sel <= 1'b0;
		i = n_fe;
		@(posedge clk);
		send_break_ctl <= 1'b1;
		@(posedge clk);
		send_break_ctl <= 1'b0;
		@(posedge clk);
		send_break_ctl <= 1'b1;
		idle(250);
		send_break_ctl <= 1'b0;
		wait_flag(1'b1, 1'b1);
		check(n_fe - i >= 3, "repeated break");
		idle(250);
		// enable toggle mid-frame adds a whole idle character
		dev_send(9'h0C3);
		wait_flag(1'b1, 1'b0);
		@(posedge clk);
		transmitter_on <= 1'b0;
		@(posedge clk);
		transmitter_on <= 1'b1;
		for (i = 2; i < 1000 && tx_complete_flag !== 1'b1; i++)
			@(negedge clk);
		check(i >= 300 && i <= 345, "idle char");
		idle(50);
		// disable mid-frame: frame finishes, then pin is let go
		dev_send(9'h055);
		wait_flag(1'b1, 1'b0);
		@(posedge clk);
		transmitter_on <= 1'b0;
		get_rx(1'b1, 9'h055, 1'b0, "sent after off");
		wait_flag(1'b1, 1'b1);
		idle(4);
		check(link.dev_txd_oe === 1'b0, "pin kept");
		check(link.far_rxd === 1'b1, "released line not idle");
		complete_run();
	end
endmodule : uart_break_idle_framing_tb
`default_nettype wire

// ==== verilog/baud_rx.sv ====
// baud tick generator plus frame receiver, used by both ends
// assumes: rxd already passed through a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module baud_rx #(
	parameter int DIV_W = sfr_pkg::DIV_W
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [DIV_W-1:0] baud_div,
	input  wire logic             rx_en,
	input  wire logic             nine_bit_sel,
	input  wire logic             rxd,
	output logic                  os_tick,
	output logic                  bit_tick,
	output logic                  rx_valid,
	output logic [8:0]            rx_data,
	output logic                  framing_error_flag
);
	// ----------------------------------------------------------------
	// modulo divider: one oversample tick per baud_div clocks
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_cnt;
	logic [3:0]       os_cnt;
	logic             div_hit;
	assign div_hit = (div_cnt + DIV_W'(1)) >= baud_div;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= '0;
			os_tick <= 1'b0;
		end else if (ce) begin
			div_cnt <= div_hit ? '0 : div_cnt + DIV_W'(1);
			os_tick <= div_hit;
		end
	end

	// bit tick every sixteen oversample ticks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			os_cnt   <= '0;
			bit_tick <= 1'b0;
		end else if (ce) begin
			bit_tick <= div_hit && (os_cnt == sfr_pkg::OS_RATE);
			if (div_hit)
				os_cnt <= os_cnt + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// receiver: start detect, mid-bit sampling, lsb first
	// ----------------------------------------------------------------
	sfr_pkg::rx_state_t rx_st;
	logic [3:0] rx_os;
	logic [3:0] rx_bit;
	logic [9:0] rx_sh;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st              <= sfr_pkg::RX_WAIT;
			rx_os              <= '0;
			rx_bit             <= '0;
			rx_sh              <= '0;
			rx_valid           <= 1'b0;
			rx_data            <= sfr_pkg::DATA_RESET;
			framing_error_flag <= 1'b0;
		end else if (ce) begin
			rx_valid <= 1'b0;
			if (!rx_en) begin
				rx_st <= sfr_pkg::RX_WAIT;
			end else if (os_tick) begin
				case (rx_st)
					sfr_pkg::RX_WAIT: begin
						rx_os <= '0;
						if (!rxd)
							rx_st <= sfr_pkg::RX_START;
					end
					sfr_pkg::RX_START: begin
						rx_os <= rx_os + 4'h1;
						if (rx_os == sfr_pkg::OS_MID) begin
							rx_os  <= '0;
							rx_bit <= '0;
							rx_st  <= rxd ? sfr_pkg::RX_WAIT
							              : sfr_pkg::RX_BITS;
						end
					end
					sfr_pkg::RX_BITS: begin
						rx_os <= rx_os + 4'h1;
						if (rx_os == sfr_pkg::OS_RATE) begin
							rx_sh  <= {rxd, rx_sh[9:1]};
							rx_bit <= rx_bit + 4'h1;
							// data bits then stop: frame minus start
							if (rx_bit == sfr_pkg::frame_len(nine_bit_sel)
							              - 4'h2) begin
								rx_st    <= sfr_pkg::RX_WAIT;
								rx_valid <= 1'b1;
								rx_data  <= nine_bit_sel ? rx_sh[9:1]
								                         : {1'b0, rx_sh[9:2]};
								framing_error_flag <= !rxd;
							end
						end
					end
					default: rx_st <= sfr_pkg::RX_WAIT;
				endcase
			end
		end
	end
endmodule : baud_rx
`default_nettype wire

// ==== verilog/sci_dev_end.sv ====
// device end: buffered transmitter with queued break/idle, plus receiver
// assumes: software drives control bits as levels on the same clk
`timescale 1ns/1ps
`default_nettype none
module sci_dev_end #(
	parameter int DIV_W = sfr_pkg::DIV_W
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	serial_link_if.device         link,
	input  wire logic [DIV_W-1:0] baud_div,
	input  wire logic             transmitter_on,
	input  wire logic             receiver_on,
	input  wire logic             send_break_ctl,
	input  wire logic             long_break_sel,
	input  wire logic             nine_bit_sel,
	input  wire logic             tx_write,
	input  wire logic [8:0]       tx_wdata,
	output logic                  tx_buffer_empty_flag,
	output logic                  tx_complete_flag,
	output logic                  rx_valid,
	output logic [8:0]            rx_data,
	output logic                  framing_error_flag
);
	// ----------------------------------------------------------------
	// line synchroniser and shared baud/receiver
	// ----------------------------------------------------------------
	logic rxd_m, rxd_s;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxd_m <= 1'b1;
			rxd_s <= 1'b1;
		end else if (ce) begin
			rxd_m <= link.dev_rxd;
			rxd_s <= rxd_m;
		end
	end

	logic bit_tick;
	baud_rx #(.DIV_W(DIV_W)) u_brx (
		.clk(clk), .nrst(nrst), .ce(ce), .baud_div(baud_div),
		.rx_en(receiver_on), .nine_bit_sel(nine_bit_sel), .rxd(rxd_s),
		.os_tick(), .bit_tick(bit_tick), .rx_valid(rx_valid),
		.rx_data(rx_data), .framing_error_flag(framing_error_flag)
	);

	// ----------------------------------------------------------------
	// control edges: break on falling edge, idle on rising edge
	// ----------------------------------------------------------------
	logic brk_d, ten_d;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_d <= 1'b0;
			ten_d <= 1'b0;
		end else if (ce) begin
			brk_d <= send_break_ctl;
			ten_d <= transmitter_on;
		end
	end
	logic brk_fall, ten_rise;
	assign brk_fall = brk_d && !send_break_ctl;
	assign ten_rise = !ten_d && transmitter_on;

	// ----------------------------------------------------------------
	// transmit shifter state
	// ----------------------------------------------------------------
	logic                 busy;
	sfr_pkg::shift_kind_t kind;
	logic [10:0]          sh;
	logic [3:0]           left;
	logic                 owns_pin;
	logic [8:0]           buf_data;
	logic                 buf_full;
	logic                 brk_q;   // queued break
	logic                 idle_q;  // queued idle
	logic                 idle_first; // idle requested before pending break
	logic                 load;
	logic                 done;

	// shifter frees on the last bit tick of its contents
	assign done = busy && bit_tick && (left == 4'h1);
	// a new load waits for a bit tick so frames align to baud
	assign load = bit_tick && (!busy || done);

	// ----------------------------------------------------------------
	// queue bookkeeping; a new request wins over a same-cycle take
	// ----------------------------------------------------------------
	logic take_brk, take_idle, take_data;
	always_comb begin
		take_brk  = 1'b0;
		take_idle = 1'b0;
		take_data = 1'b0;
		if (load) begin
			// order of request among break and idle, then data
			if (idle_q && (idle_first || !brk_q))
				take_idle = 1'b1;
			else if (brk_q)
				take_brk = 1'b1;
			else if (buf_full && transmitter_on)
				take_data = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_q      <= 1'b0;
			idle_q     <= 1'b0;
			idle_first <= 1'b0;
		end else if (ce) begin
			// break control still high at transfer queues another
			if (brk_fall || (take_brk && send_break_ctl))
				brk_q <= 1'b1;
			else if (take_brk)
				brk_q <= 1'b0;
			if (ten_rise)
				idle_q <= 1'b1;
			else if (take_idle)
				idle_q <= 1'b0;
			if (ten_rise && !brk_q)
				idle_first <= 1'b1;
			else if (brk_fall && !idle_q)
				idle_first <= 1'b0;
		end
	end

	// transmit buffer and its empty flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_full <= 1'b0;
			buf_data <= sfr_pkg::DATA_RESET;
		end else if (ce) begin
			if (tx_write) begin
				buf_full <= 1'b1;
				buf_data <= tx_wdata;
			end else if (take_data) begin
				buf_full <= 1'b0;
			end
		end
	end
	assign tx_buffer_empty_flag = !buf_full;

	// shifter load and shift
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			kind <= sfr_pkg::SH_DATA;
			sh   <= '1;
			left <= '0;
		end else if (ce) begin
			if (take_brk) begin
				busy <= 1'b1;
				kind <= sfr_pkg::SH_BREAK;
				sh   <= '0;
				left <= sfr_pkg::break_len(long_break_sel, nine_bit_sel);
			end else if (take_idle) begin
				busy <= 1'b1;
				kind <= sfr_pkg::SH_IDLE;
				sh   <= '1;
				left <= sfr_pkg::frame_len(nine_bit_sel);
			end else if (take_data) begin
				busy <= 1'b1;
				kind <= sfr_pkg::SH_DATA;
				// stop level, not bit 8, closes an eight-bit frame
				sh   <= {1'b1, nine_bit_sel ? buf_data[8] : 1'b1,
				         buf_data[7:0], 1'b0};
				left <= sfr_pkg::frame_len(nine_bit_sel);
			end else if (done) begin
				busy <= 1'b0;
				sh   <= '1;
				left <= '0;
			end else if (busy && bit_tick) begin
				sh   <= (kind == sfr_pkg::SH_BREAK) ? '0 : {1'b1, sh[10:1]};
				left <= left - 4'h1;
			end
		end
	end

	// complete flag: set when shifter idles with nothing queued
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_complete_flag <= 1'b1;
		end else if (ce) begin
			if (take_brk || take_idle || take_data)
				tx_complete_flag <= 1'b0;
			else if (done)
				tx_complete_flag <= 1'b1;
		end
	end

	// pin ownership: kept while enabled or any work pending
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			owns_pin <= 1'b0;
		end else if (ce) begin
			owns_pin <= transmitter_on || busy || brk_q || idle_q;
		end
	end
	assign link.dev_txd_oe = owns_pin;
	assign link.dev_txd_o  = busy ? sh[0] : 1'b1;
endmodule : sci_dev_end
`default_nettype wire

// ==== verilog/sci_far_end.sv ====
// partner end: sends data frames on request and receives frames
// assumes: same clk; software keeps idle gaps between messages
`timescale 1ns/1ps
`default_nettype none
module sci_far_end #(
	parameter int DIV_W = sfr_pkg::DIV_W
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	serial_link_if.far            link,
	input  wire logic [DIV_W-1:0] baud_div,
	input  wire logic             nine_bit_sel,
	input  wire logic             send_valid,
	input  wire logic [8:0]       send_data,
	output logic                  send_ready,
	output logic                  rx_valid,
	output logic [8:0]            rx_data,
	output logic                  framing_error_flag
);
	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	logic rxd_m, rxd_s;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxd_m <= 1'b1;
			rxd_s <= 1'b1;
		end else if (ce) begin
			rxd_m <= link.far_rxd;
			rxd_s <= rxd_m;
		end
	end

	logic bit_tick;
	baud_rx #(.DIV_W(DIV_W)) u_brx (
		.clk(clk), .nrst(nrst), .ce(ce), .baud_div(baud_div),
		.rx_en(1'b1), .nine_bit_sel(nine_bit_sel), .rxd(rxd_s),
		.os_tick(), .bit_tick(bit_tick), .rx_valid(rx_valid),
		.rx_data(rx_data), .framing_error_flag(framing_error_flag)
	);

	// ----------------------------------------------------------------
	// transmitter: start, data lsb first, stop; idle high between
	// ----------------------------------------------------------------
	logic [10:0] sh;
	logic [3:0]  left;
	logic        busy;
	// take a request only on a bit tick, so the start bit is whole
	assign send_ready = !busy && bit_tick;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh   <= '1;
			left <= '0;
			busy <= 1'b0;
		end else if (ce) begin
			if (send_ready && send_valid) begin
				// stop level, not bit 8, closes an eight-bit frame
				sh   <= {1'b1, nine_bit_sel ? send_data[8] : 1'b1,
				         send_data[7:0], 1'b0};
				left <= sfr_pkg::frame_len(nine_bit_sel);
				busy <= 1'b1;
			end else if (busy && bit_tick) begin
				if (left == 4'h1) begin
					busy <= 1'b0;
					sh   <= '1;
				end else begin
					sh <= {1'b1, sh[10:1]};
				end
				left <= left - 4'h1;
			end
		end
	end
	// idle line stays high between messages for wakeup use
	assign link.far_txd_o  = busy ? sh[0] : 1'b1;
	assign link.far_txd_oe = 1'b1;
endmodule : sci_far_end
`default_nettype wire
